// ---- shared/touch_cfg.svh ----
// What this block does
// - Fifteen channels, manual or automatic, one active
// - Scanned pin loses pull-up, restored when idle
// - Trigger rising edge starts one manual conversion
// - Hardware clears trigger at conversion end
// - Done flag low while running, high after
// - Ten-bit count split high and low parts
// - Overflow flag when conversion exceeds period
// - Three-bit period field scales the count
// - Channel codes 0 to 14 pick channels
// - Code fifteen measures internal reference capacitor
// - Automatic scanning covers channels zero to three
// - Automatic scanning runs in every power mode
// - Auto select hands sequencing to hardware
// - Enabled channels measured periodically in auto mode
// - Count below threshold raises interrupt flag
// - Interval 4096 or 2048 slow-clock cycles
// - Two-bit field sets auto channel count
// - Auto result bit n marks channel n touched
// - Touch flag set by hardware, cleared by service/write
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_IRQ_FLAG     8'h95
`define IDX_STATUS       8'hab
`define IDX_COUNT_LOW    8'hac
`define IDX_TOUCH_CTL    8'had
`define IDX_AUTO_CTL     8'hae
`define IDX_THRESH_BASE  8'hc4
`define IDX_AUX_ONE      8'hf8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TOUCH_CTL    8'hcf
`define RST_AUTO_CTL     4'h3
`define RST_AUX_ONE      5'h00
`define RST_THRESH       8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_POWER_DOWN   7
`define BIT_TRIGGER      4
`define BIT_AUTO_SEL     3
`define BIT_AUTO_RATE    2
`define BIT_IRQ_FLAG     3
`define REF_CAP_CODE     4'hf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCAN_LONG_TICKS  4096
`define SCAN_SHORT_TICKS 2048
`define CHARGE_BASE_CYC  2
`define COUNT_MAX        10'h3ff

`endif

// ---- shared/touch_pkg.sv ----
package touch_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MAN_RUN,
    ST_AUTO_START,
    ST_AUTO_RUN
  } scan_state_e;

  // One finished conversion
  typedef struct packed {
    logic       ovf;
    logic [9:0] count;
  } conv_result_s;

endpackage

// ---- rtl/touch_counter.sv ----
`timescale 1ns/10ps
`include "touch_cfg.svh"
module touch_counter #(
  parameter int CHARGE_BASE = `CHARGE_BASE_CYC
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Control
  input  wire logic                   start_i,
  input  wire logic [2:0]             period_i,
  input  wire logic                   trip_i,
  // Result
  output logic                        busy_o,
  output logic                        done_o,
  output touch_pkg::conv_result_s     result_o
);
  import touch_pkg::*;

  // Base shifted by seven must still fit the 16-bit divider
  generate
    if (CHARGE_BASE < 1 || CHARGE_BASE > 511) begin : g_bad
      $error("CHARGE_BASE must be 1 to 511");
    end
  endgenerate

  logic         busy_q, busy_d;       // Conversion running
  logic         done_q, done_d;       // End pulse
  logic [2:0]   per_q, per_d;         // Latched period select
  logic [15:0]  div_q, div_d;         // Charge tick divider
  logic [9:0]   cnt_q, cnt_d;         // Charge pulses so far
  conv_result_s res_q, res_d;         // Last result

  // Tick length shrinks as the period code grows
  function automatic logic [15:0] tick_len(input logic [2:0] p);
    tick_len = 16'(CHARGE_BASE) << (3'd7 - p);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    per_d  = per_q;
    div_d  = div_q;
    cnt_d  = cnt_q;
    res_d  = res_q;
    if (start_i && !busy_q) begin
      per_d  = period_i;
      busy_d = 1'b1;
      div_d  = 16'h0000;
      cnt_d  = 10'h000;
    end else if (busy_q) begin
      if (trip_i) begin
        // Capacitor charged, count is final
        busy_d       = 1'b0;
        done_d       = 1'b1;
        res_d.count  = cnt_q;
        res_d.ovf    = 1'b0;
      end else if (div_q == tick_len(per_q) - 16'h0001) begin
        div_d = 16'h0000;
        if (cnt_q == `COUNT_MAX) begin
          busy_d      = 1'b0;
          done_d      = 1'b1;
          res_d.count = `COUNT_MAX;
          res_d.ovf   = 1'b1;
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end else begin
        div_d = div_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      per_q  <= 3'h0;
      div_q  <= 16'h0000;
      cnt_q  <= 10'h000;
      res_q  <= '0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      per_q  <= per_d;
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      res_q  <= res_d;
    end
  end

  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign result_o = res_q;
endmodule

// ---- rtl/touch_scan_core.sv ----
`timescale 1ns/10ps
`include "touch_cfg.svh"
module touch_scan_core #(
  parameter int SCAN_LONG   = `SCAN_LONG_TICKS,
  parameter int SCAN_SHORT  = `SCAN_SHORT_TICKS,
  parameter int CHARGE_BASE = `CHARGE_BASE_CYC
) (
  // Clock and reset
  input  wire logic         REF_CLK_I,
  input  wire logic         RST_N_I,
  // APB slave
  input  wire logic         PSEL_I,
  input  wire logic         PENABLE_I,
  input  wire logic         PWRITE_I,
  input  wire logic [11:0]  PADDR_I,
  input  wire logic [31:0]  PWDATA_I,
  output logic [31:0]       PRDATA_O,
  output logic              PREADY_O,
  output logic              PSLVERR_O,
  // Analog side and slow clock
  input  wire logic         SLOW_CLK_I,
  input  wire logic         INTEGRATION_CAPACITOR_PIN_I,
  output logic [14:0]       PULLUP_OFF_O,
  output logic [3:0]        SENSE_SEL_O,
  output logic              REF_CAP_SEL_O,
  output logic              CHARGE_EN_O,
  // Processor side
  input  wire logic         IRQ_SERVICE_I,
  output logic              TOUCH_IRQ_O
);
  import touch_pkg::*;

  generate
    if (SCAN_LONG < 2 || SCAN_LONG > 4096 || SCAN_SHORT < 2 ||
        SCAN_SHORT > SCAN_LONG) begin : g_bad
      $error("Scan intervals out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] trip_sync_q;            // Trip comparator, two flops
  logic [2:0] slow_sync_q;            // Slow clock, two flops + edge
  logic       trip_s;                 // Synchronised trip
  logic       slow_tick;              // One pulse per slow cycle

  // Pins are asynchronous to the system clock
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trip_sync_q <= 2'b00;
      slow_sync_q <= 3'b000;
    end else begin
      trip_sync_q <= {trip_sync_q[0], INTEGRATION_CAPACITOR_PIN_I};
      slow_sync_q <= {slow_sync_q[1:0], SLOW_CLK_I};
    end
  end

  assign trip_s    = trip_sync_q[1];
  assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       wr_en;                  // Write takes effect now
  logic       rd_setup;               // Read captured in setup

  // Index match of a word address
  function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
    hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, i});
  endfunction

  // Any mapped register
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `IDX_IRQ_FLAG)  || hit(a, `IDX_STATUS)   ||
             hit(a, `IDX_COUNT_LOW) || hit(a, `IDX_TOUCH_CTL) ||
             hit(a, `IDX_AUTO_CTL)  || hit(a, `IDX_AUX_ONE)  ||
             (a[1:0] == 2'b00 && a[11:4] == {2'b00, 6'h31});
  endfunction

  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // ----------------------------------------------------------------
  // Register file and flags
  // ----------------------------------------------------------------
  logic [7:0]   ctl_q, ctl_d;         // Power down, period, channel
  logic [3:0]   actl_q, actl_d;       // Auto select, rate, count
  logic [4:0]   aux_q, aux_d;         // Trigger and spare bits
  logic [7:0]   thr_q [4];            // Auto compare thresholds
  logic [7:0]   thr_d [4];
  logic         irq_q, irq_d;         // Touch interrupt flag
  logic         eoc_q, eoc_d;         // Manual conversion done
  conv_result_s res_q, res_d;         // Manual result
  logic [3:0]   auto_touch_result_q, auto_touch_result_d; // Auto result
  logic [31:0]  rdata_q, rdata_d;     // Read data
  logic         slverr_q, slverr_d;   // Unmapped access

  // Sequencer hooks into the register group
  logic         man_done;             // Manual conversion finished
  logic         auto_done;            // Auto channel finished
  logic         touched;              // Count under threshold
  logic [1:0]   auto_ch_q;            // Channel in auto scan
  conv_result_s conv_res;             // Counter result
  logic         conv_busy;            // Counter running
  logic         conv_done;            // Counter end pulse
  logic         ctl_start_man;        // Manual start accepted

  // Software writes and hardware updates
  always_comb begin
    ctl_d    = ctl_q;
    actl_d   = actl_q;
    aux_d    = aux_q;
    thr_d    = thr_q;
    irq_d    = irq_q;
    eoc_d    = eoc_q;
    res_d    = res_q;
    auto_touch_result_d = auto_touch_result_q;
    rdata_d  = rdata_q;
    slverr_d = slverr_q;
    if (man_done) begin
      aux_d[`BIT_TRIGGER] = 1'b0;
    end
    if (IRQ_SERVICE_I) begin
      irq_d = 1'b0;
    end
    if (wr_en) begin
      if (hit(PADDR_I, `IDX_TOUCH_CTL)) begin
        ctl_d = PWDATA_I[7:0];
      end
      if (hit(PADDR_I, `IDX_AUTO_CTL)) begin
        actl_d = PWDATA_I[3:0];
      end
      if (hit(PADDR_I, `IDX_AUX_ONE)) begin
        aux_d = PWDATA_I[4:0];
      end
      if (hit(PADDR_I, `IDX_IRQ_FLAG) && !PWDATA_I[`BIT_IRQ_FLAG]) begin
        irq_d = 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
        if (hit(PADDR_I, `IDX_THRESH_BASE + 8'(i))) begin
          thr_d[i] = PWDATA_I[7:0];
        end
      end
    end
    if (ctl_start_man) begin
      eoc_d = 1'b0;
    end
    if (man_done) begin
      eoc_d = 1'b1;
      res_d = conv_res;
    end
    if (auto_done) begin
      auto_touch_result_d[auto_ch_q] = touched;
      if (touched) begin
        irq_d = 1'b1;
      end
    end
    // Read data captured in setup phase
    if (rd_setup) begin
      rdata_d = 32'h0000_0000;
      if (hit(PADDR_I, `IDX_IRQ_FLAG)) begin
        rdata_d[`BIT_IRQ_FLAG] = irq_q;
      end
      if (hit(PADDR_I, `IDX_STATUS)) begin
        rdata_d[7:0] = {eoc_q, res_q.ovf, res_q.count[9:8],
                        auto_touch_result_q};
      end
      if (hit(PADDR_I, `IDX_COUNT_LOW)) begin
        rdata_d[7:0] = res_q.count[7:0];
      end
      if (hit(PADDR_I, `IDX_TOUCH_CTL)) begin
        rdata_d[7:0] = ctl_q;
      end
      if (hit(PADDR_I, `IDX_AUTO_CTL)) begin
        rdata_d[3:0] = actl_q;
      end
      if (hit(PADDR_I, `IDX_AUX_ONE)) begin
        rdata_d[4:0] = aux_q;
      end
      for (int i = 0; i < 4; i++) begin
        if (hit(PADDR_I, `IDX_THRESH_BASE + 8'(i))) begin
          rdata_d[7:0] = thr_q[i];
        end
      end
    end
    if (PSEL_I && !PENABLE_I) begin
      slverr_d = !mapped(PADDR_I);
    end
  end

  // Register file flops
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_q    <= `RST_TOUCH_CTL;
      actl_q   <= `RST_AUTO_CTL;
      aux_q    <= `RST_AUX_ONE;
      thr_q    <= '{default: `RST_THRESH};
      irq_q    <= 1'b0;
      eoc_q    <= 1'b0;
      res_q    <= '0;
      auto_touch_result_q <= 4'h0;
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      ctl_q    <= ctl_d;
      actl_q   <= actl_d;
      aux_q    <= aux_d;
      thr_q    <= thr_d;
      irq_q    <= irq_d;
      eoc_q    <= eoc_d;
      res_q    <= res_d;
      auto_touch_result_q <= auto_touch_result_d;
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  scan_state_e st_q, st_d;            // Sequencer state
  logic [1:0]  auto_ch_d;
  logic        trig_prev_q;           // Trigger bit last cycle
  logic        due_q, due_d;          // Auto scan pending
  logic [11:0] ivl_q, ivl_d;          // Slow ticks in interval
  logic [11:0] ivl_last;              // Last tick of interval
  logic        start_conv;            // Pulse to counter
  logic        act_q, act_d;          // Pin under scan
  logic [3:0]  sel_q, sel_d;          // Channel under scan
  logic        auto_on;               // Hardware owns the unit

  // one mode, chosen by auto select
  assign auto_on  = actl_q[`BIT_AUTO_SEL];
  assign ivl_last = actl_q[`BIT_AUTO_RATE] ? 12'(SCAN_SHORT - 1)
                                           : 12'(SCAN_LONG - 1);
  assign ctl_start_man = (st_q == ST_IDLE) && !auto_on &&
                         !ctl_q[`BIT_POWER_DOWN] &&
                         aux_q[`BIT_TRIGGER] && !trig_prev_q;
  assign man_done  = (st_q == ST_MAN_RUN) && conv_done;
  assign auto_done = (st_q == ST_AUTO_RUN) && conv_done;
  assign touched   = conv_res.ovf ? 1'b0
                     : (conv_res.count < {2'b00, thr_q[auto_ch_q]});

  // Next sequencer state
  always_comb begin
    st_d       = st_q;
    auto_ch_d  = auto_ch_q;
    due_d      = due_q;
    ivl_d      = ivl_q;
    act_d      = act_q;
    sel_d      = sel_q;
    start_conv = 1'b0;
    // interval runs from slow clock only
    if (!auto_on) begin
      ivl_d = 12'h000;
      due_d = 1'b0;
    end else if (slow_tick) begin
      if (ivl_q >= ivl_last) begin
        ivl_d = 12'h000;
        due_d = 1'b1;
      end else begin
        ivl_d = ivl_q + 12'h001;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (ctl_start_man) begin
          start_conv = 1'b1;
          sel_d      = ctl_q[3:0];
          act_d      = 1'b1;
          st_d       = ST_MAN_RUN;
        end else if (auto_on && due_q) begin
          due_d     = 1'b0;
          auto_ch_d = 2'b00;
          st_d      = ST_AUTO_START;
        end
      end
      ST_MAN_RUN: begin
        if (conv_done) begin
          act_d = 1'b0;
          st_d  = ST_IDLE;
        end
      end
      ST_AUTO_START: begin
        // auto channels only zero to three
        start_conv = 1'b1;
        sel_d      = {2'b00, auto_ch_q};
        act_d      = 1'b1;
        st_d       = ST_AUTO_RUN;
      end
      ST_AUTO_RUN: begin
        if (conv_done) begin
          act_d = 1'b0;
          if (auto_ch_q == actl_q[1:0] || !auto_on) begin
            st_d = ST_IDLE;
          end else begin
            auto_ch_d = auto_ch_q + 2'b01;
            st_d      = ST_AUTO_START;
          end
        end
      end
      default: begin
        st_d  = ST_IDLE;
        act_d = 1'b0;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q        <= ST_IDLE;
      auto_ch_q   <= 2'b00;
      trig_prev_q <= 1'b0;
      due_q       <= 1'b0;
      ivl_q       <= 12'h000;
      act_q       <= 1'b0;
      sel_q       <= 4'h0;
    end else begin
      st_q        <= st_d;
      auto_ch_q   <= auto_ch_d;
      trig_prev_q <= aux_q[`BIT_TRIGGER];
      due_q       <= due_d;
      ivl_q       <= ivl_d;
      act_q       <= act_d;
      sel_q       <= sel_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion counter
  // ----------------------------------------------------------------
  touch_counter #(
    .CHARGE_BASE (CHARGE_BASE)
  ) u_counter (
    .clk_i    (REF_CLK_I),
    .rst_n_i  (RST_N_I),
    .start_i  (start_conv),
    .period_i (ctl_q[6:4]),
    .trip_i   (trip_s),
    .busy_o   (conv_busy),
    .done_o   (conv_done),
    .result_o (conv_res)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // pull-up off only on scanned pin
  always_comb begin
    PULLUP_OFF_O = 15'h0000;
    if (act_q && sel_q != `REF_CAP_CODE) begin
      PULLUP_OFF_O[sel_q] = 1'b1;
    end
  end

  assign SENSE_SEL_O   = sel_q;
  assign REF_CAP_SEL_O = act_q && (sel_q == `REF_CAP_CODE);
  assign CHARGE_EN_O   = conv_busy;
  assign TOUCH_IRQ_O   = irq_q;
  assign PRDATA_O      = rdata_q;
  assign PREADY_O      = 1'b1;
  assign PSLVERR_O     = slverr_q;
endmodule

// ---- tb/touch_properties.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port-level checks on the scan sequencer outputs
// ------------------------------------------------------------
module touch_properties #(
  parameter int CHARGE_BASE = 1
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // Analog and processor side
  input  wire logic        INTEGRATION_CAPACITOR_PIN_I,
  input  wire logic        IRQ_SERVICE_I,
  input  wire logic [14:0] PULLUP_OFF_O,
  input  wire logic [3:0]  SENSE_SEL_O,
  input  wire logic        REF_CAP_SEL_O,
  input  wire logic        CHARGE_EN_O,
  input  wire logic        TOUCH_IRQ_O
);
  // Longest legal run: 1024 ticks at the slowest period, plus slack
  localparam int RUN_MAX = CHARGE_BASE * 128 * 1024 + 16;

  logic [19:0] run_q;   // Cycles of the current charge run
  logic [19:0] run_d;   // Next run count

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Count only while charging, so a stuck counter shows up
  always_comb begin
    run_d = CHARGE_EN_O ? run_q + 20'h1 : 20'h0;
  end

  // Register the run count
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      run_q <= 20'h0;
    end else begin
      run_q <= run_d;
    end
  end

  AST_ONE_PIN: assert property ($onehot0(PULLUP_OFF_O))
    else $error("more than one pull-up released");
  AST_PIN_MATCH: assert property (PULLUP_OFF_O != 15'h0 |->
    PULLUP_OFF_O == (15'h1 << SENSE_SEL_O))
    else $error("released pull-up is not the selected pin");
  AST_REF_NO_PIN: assert property (REF_CAP_SEL_O |->
    PULLUP_OFF_O == 15'h0 && SENSE_SEL_O == 4'hf)
    else $error("reference scan touches a pin");
  AST_IRQ_LOW_CHAN: assert property ($rose(TOUCH_IRQ_O) |->
    SENSE_SEL_O <= 4'h3)
    else $error("touch flag raised from a high channel");
  AST_SERVICE_CLR: assert property (IRQ_SERVICE_I && !CHARGE_EN_O &&
    $past(CHARGE_EN_O, 4) == 1'b0 |=> !TOUCH_IRQ_O)
    else $error("service entry left touch flag set");
  AST_RUN_LIMIT: assert property (run_q <= RUN_MAX)
    else $error("charge run exceeds overflow limit");
  AST_TRIP_ENDS: assert property (INTEGRATION_CAPACITOR_PIN_I &&
    CHARGE_EN_O |-> ##[1:6] !CHARGE_EN_O)
    else $error("trip did not end the conversion");
  AST_SEL_HELD: assert property (CHARGE_EN_O && $past(CHARGE_EN_O) |->
    $stable(SENSE_SEL_O))
    else $error("channel changed during a run");

  COV_IRQ: cover property ($rose(TOUCH_IRQ_O));
  COV_REF: cover property ($rose(REF_CAP_SEL_O));
  COV_END: cover property ($fell(CHARGE_EN_O));
endmodule

bind touch_scan_core touch_properties #(
  .CHARGE_BASE(CHARGE_BASE)
) i_props (
  .REF_CLK_I(REF_CLK_I),
  .RST_N_I(RST_N_I),
  .INTEGRATION_CAPACITOR_PIN_I(INTEGRATION_CAPACITOR_PIN_I),
  .IRQ_SERVICE_I(IRQ_SERVICE_I),
  .PULLUP_OFF_O(PULLUP_OFF_O),
  .SENSE_SEL_O(SENSE_SEL_O),
  .REF_CAP_SEL_O(REF_CAP_SEL_O),
  .CHARGE_EN_O(CHARGE_EN_O),
  .TOUCH_IRQ_O(TOUCH_IRQ_O)
);

// ---- tb/touch_pad_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Electrode and integration capacitor: trips after a set time
// ------------------------------------------------------------
module touch_pad_model (
  // Clock and charge control
  input  wire logic        clk_i,
  input  wire logic        charge_en_i,
  // Charge cycles to trip, zero never trips
  input  wire logic [11:0] trip_cyc_i,
  // Comparator output
  output logic             trip_o
);
  logic [11:0] cnt_q;   // Cycles charged so far

  // Capacitor discharges whenever charging stops
  always_ff @(posedge clk_i) begin
    cnt_q <= charge_en_i ? cnt_q + 12'h1 : 12'h0;
  end

  // Comparator drops as soon as charging stops
  assign trip_o = charge_en_i && trip_cyc_i != 12'h0 &&
                  cnt_q >= trip_cyc_i;
endmodule

// ---- tb/capacitive_touch_scan_controller_tb.sv ----
`timescale 1ns/10ps
`include "touch_cfg.svh"
module capacitive_touch_scan_controller_tb;
  logic        clk, rst_n, psel, penable, pwrite, slow, svc, err;
  logic        pready, pslverr, trip, ref_sel, chg, irq, ref_seen;
  logic        auto_on;
  logic [11:0] paddr, trip_cyc;
  logic [31:0] pwdata, prdata, rd, st, lo;
  logic [14:0] pu, pu_seen;
  logic [3:0]  sel;
  logic [9:0]  c7, c6;
  int          bad_count, checked;

  // Slow tick parameters shortened so auto scans come quickly
  touch_scan_core #(.SCAN_LONG(8), .SCAN_SHORT(4), .CHARGE_BASE(1)) i_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SLOW_CLK_I(slow),
    .INTEGRATION_CAPACITOR_PIN_I(trip),
    .PULLUP_OFF_O(pu), .SENSE_SEL_O(sel), .REF_CAP_SEL_O(ref_sel),
    .CHARGE_EN_O(chg), .IRQ_SERVICE_I(svc), .TOUCH_IRQ_O(irq));
  touch_pad_model i_pad (.clk_i(clk), .charge_en_i(chg),
    .trip_cyc_i(trip_cyc), .trip_o(trip));

  initial begin clk = 0; forever #2.5 clk = ~clk; end
  initial begin slow = 0; forever #40 slow = ~slow; end

  // ----------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Automatic: the monitor calls it alongside the main sequence
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------
  // APB master: hold the request until pready is seen high
  // ----------------------------------------------------------
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1; penable <= 0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge clk); penable <= 1;
    // No cycle limit here: only the watchdog ends a stuck wait
    do begin @(posedge clk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // One manual conversion, software side keeps the order
  task conv(input logic [31:0] ctl, input logic [11:0] tc);
    trip_cyc <= tc;
    apb(1, `IDX_TOUCH_CTL, ctl);
    apb(1, `IDX_AUX_ONE, 32'h0);
    apb(1, `IDX_AUX_ONE, 32'h10);
    repeat (2) @(posedge clk);
    pu_seen = pu; ref_seen = ref_sel;
    apb(0, `IDX_STATUS, 32'h0);
    chk(32'(rd[7]), 32'h0);
    while (rd[7] !== 1'b1) begin
      apb(0, `IDX_STATUS, 32'h0);
    end
    st = rd;
    apb(0, `IDX_COUNT_LOW, 32'h0); lo = rd;
    // settle gap before the next start
    repeat (2100) @(posedge clk);
  endtask

  // No pin above channel one may be scanned by the auto sequence
  // Sampled on the falling edge, away from the launching edge
  always @(negedge clk) if (auto_on) chk(32'(pu[14:2]), 32'h0);

  initial begin repeat (60000) @(posedge clk); bad_count++; end_of_test; end

  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    svc = 0; trip_cyc = 0; auto_on = 0; bad_count = 0; checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rchk(`IDX_TOUCH_CTL, 32'hcf);
    rchk(`IDX_AUTO_CTL, 32'h3);
    rchk(`IDX_AUX_ONE, 32'h0);
    rchk(`IDX_THRESH_BASE, 32'h40);
    apb(0, 8'h00, 32'h0);
    chk(32'(err), 32'h1);
    conv(32'h75, 12'd40);
    chk(32'({st[6], pu_seen}), 32'h20);
    c7 = {st[5:4], lo[7:0]};
    rchk(`IDX_AUX_ONE, 32'h0);
    conv(32'h65, 12'd40);
    c6 = {st[5:4], lo[7:0]};
    chk(32'(c6 < c7 && c7 > 10'd36 && c7 < 10'd48), 32'h1);
    conv(32'h7f, 12'd40);
    chk(32'({ref_seen, pu_seen}), 32'h8000);
    conv(32'h73, 12'd0);
    chk(32'({st[7:4], lo[7:0]}), 32'hfff);
    apb(1, `IDX_TOUCH_CTL, 32'hf3);
    apb(1, `IDX_AUX_ONE, 32'h0);
    apb(1, `IDX_AUX_ONE, 32'h10);
    repeat (4) @(posedge clk);
    chk(32'(chg), 32'h0);
    rchk(`IDX_COUNT_LOW, 32'hff);
    // Auto scan of two channels, only channel zero under threshold
    apb(1, `IDX_TOUCH_CTL, 32'h73);
    apb(1, `IDX_THRESH_BASE, 32'hff);
    apb(1, (`IDX_THRESH_BASE + 8'h01), 32'h05);
    trip_cyc <= 12'd20; auto_on = 1;
    apb(1, `IDX_AUTO_CTL, 32'hd);
    for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
    chk(32'(irq), 32'h1);
    rchk(`IDX_IRQ_FLAG, 32'h8);
    // Flag bit written low clears it, channel one is not touched
    apb(1, `IDX_IRQ_FLAG, 32'hf7);
    chk(32'(irq), 32'h0);
    // Next interval scans channel zero again and sets the flag
    for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1, `IDX_AUTO_CTL, 32'h0);
    for (int n = 0; n < 2000 && chg !== 1'b0; n++) @(posedge clk);
    auto_on = 0;
    apb(0, `IDX_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'h1);
    svc <= 1;
    @(posedge clk);
    svc <= 0;
    @(posedge clk);
    chk(32'(irq), 32'h0);
    // Software rescans channel zero by hand: done set, no overflow, pin zero released
    conv(32'h70, 12'd20);
    chk(32'({st[7:6], pu_seen}), 32'h1_0001);
    end_of_test;
  end
endmodule
